// file: rtl/flash_access_pkg.sv
// constants and types for the flash sector access controller
package flash_access_pkg;
  // register port offsets
  localparam logic [2:0] ADDR_CTRL  = 3'h0;
  localparam logic [2:0] ADDR_GUARD = 3'h1;
  localparam logic [2:0] ADDR_ADRLO = 3'h2;
  localparam logic [2:0] ADDR_ADRHI = 3'h3;
  localparam logic [2:0] ADDR_DATA  = 3'h4;
  localparam logic [2:0] ADDR_STAT  = 3'h5;
  localparam logic [2:0] ADDR_LINK  = 3'h6;
  // control bits, one per operation, in flash_op_t order
  localparam int unsigned CTRL_PGM = 0;
  localparam int unsigned CTRL_SER = 1;
  localparam int unsigned CTRL_MER = 2;
  localparam int unsigned CTRL_OPT = 3;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  // status bits
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_ERR  = 1;
  localparam int unsigned STAT_RDP  = 2;
  localparam int unsigned STAT_ATT  = 3;
  localparam int unsigned STAT_RXV  = 4;
  localparam int unsigned STAT_TXP  = 5;
  localparam int unsigned STAT_ARM  = 6;
  // option byte bit that holds read-out protection
  localparam int unsigned RDP_BIT = 0;
  // access guard key sequence
  localparam logic [7:0] GUARD_KEY1 = 8'h56;
  localparam logic [7:0] GUARD_KEY2 = 8'hAE;
  localparam logic [1:0] GUARD_IDLE = 2'h0;
  localparam logic [1:0] GUARD_HALF = 2'h1;
  localparam logic [1:0] GUARD_ARMED = 2'h2;
  // array geometry
  localparam int unsigned FLASH_KB   = 32;
  localparam logic [16:0] ADDR_TOP   = 17'h10000;
  localparam logic [16:0] KBYTE      = 17'h00400;
  localparam logic [16:0] FLASH_BASE =
    17'(ADDR_TOP - 17'(FLASH_KB) * KBYTE);
  localparam logic [15:0] SECT0_BASE = 16'hF000;
  localparam logic [15:0] SECT1_BASE = 16'hE000;
  localparam logic [1:0]  SEC_NONE   = 2'h3;
  // serial link
  localparam logic [2:0]  LINK_LAST  = 3'h7;

  typedef enum logic [1:0] {OP_PROG, OP_SERASE, OP_MERASE, OP_OPT}
    flash_op_t;
  typedef enum logic [1:0] {MODE_IAP, MODE_ICP, MODE_TOOL} mode_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } reg_req_t;

  typedef struct packed {
    logic        req;
    flash_op_t   op;
    logic [15:0] addr;
    logic [7:0]  data;
  } flash_cmd_t;
endpackage

// file: rtl/flash_sector_access_control.sv
// flash sector access, protection and in-circuit link control
`timescale 1ns/1ps
module flash_sector_access_control
  import flash_access_pkg::*;
(
  // clock, reset, enable
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic       ce_i,
  // register port
  input  wire reg_req_t   reg_req_i,
  output logic [7:0]      rdata_o,
  // mode and tool pins
  input  wire logic       offboard_tool_i,
  input  wire logic       incircuit_comm_mode_i,
  input  wire logic       tool_attached_i,
  // in-circuit link pins
  input  wire logic       incircuit_serial_clock_i,
  input  wire logic       incircuit_serial_data_i,
  output logic            incircuit_serial_data_o,
  output logic            incircuit_serial_data_oe_o,
  // application and protection status
  output logic            app_pins_released_o,
  output logic            readout_block_o,
  // flash macro
  output flash_cmd_t      flash_cmd_o,
  input  wire logic       flash_done_i,
  input  wire logic       flash_opt_rdp_i
);

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_UNPROT_ERASE,
                            ST_UNPROT_CLR} state_t;

  // map an address to its sector, SEC_NONE below the array
  function automatic logic [1:0] sector_of(input logic [15:0] a);
    if ({1'b0, a} < FLASH_BASE) return SEC_NONE;
    else if (a >= SECT0_BASE) return 2'h0;
    else if (a >= SECT1_BASE) return 2'h1;
    else return 2'h2;
  endfunction

  state_t     state_q;
  flash_cmd_t cmd_q;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [7:0] ctrl_q;
  logic [1:0] guard_q;
  logic [15:0] addr_q;
  logic [7:0] data_q;
  logic       err_q;
  logic       rdp_q;
  logic       loaded_q;
  logic       sclk_prev_q;
  logic [2:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] rx_q;
  logic       rxv_q;
  logic [7:0] tx_q;
  logic       txp_q;
  logic       oe_q;
  logic [7:0] rdata_q;
  logic       released_q;
  logic       rblock_q;

  // pins pass two flops before use
  wire [4:0] pins_w = {incircuit_serial_data_i, incircuit_serial_clock_i,
                       tool_attached_i, incircuit_comm_mode_i,
                       offboard_tool_i};
  wire off_s  = sync2_q[0];
  wire icc_s  = sync2_q[1];
  wire att_s  = sync2_q[2];
  wire sclk_s = sync2_q[3];
  wire sdat_s = sync2_q[4];

  wire mode_t mode_w = off_s ? MODE_TOOL :
                       icc_s ? MODE_ICP : MODE_IAP;
  wire iap_w = (mode_w == MODE_IAP);

  // register decode
  wire wr_ctrl_w  = reg_req_i.we && reg_req_i.addr == ADDR_CTRL;
  wire wr_guard_w = reg_req_i.we && reg_req_i.addr == ADDR_GUARD;
  wire wr_lo_w    = reg_req_i.we && reg_req_i.addr == ADDR_ADRLO;
  wire wr_hi_w    = reg_req_i.we && reg_req_i.addr == ADDR_ADRHI;
  wire wr_data_w  = reg_req_i.we && reg_req_i.addr == ADDR_DATA;
  wire wr_stat_w  = reg_req_i.we && reg_req_i.addr == ADDR_STAT;
  wire wr_link_w  = reg_req_i.we && reg_req_i.addr == ADDR_LINK;
  wire rd_link_w  = reg_req_i.re && reg_req_i.addr == ADDR_LINK;

  // start request evaluation
  wire idle_w   = (state_q == ST_IDLE);
  wire armed_w  = (guard_q == GUARD_ARMED);
  wire op_hit_w = |reg_req_i.wdata[CTRL_OPT:CTRL_PGM];
  wire flash_op_t op_w = reg_req_i.wdata[CTRL_PGM] ? OP_PROG   :
                         reg_req_i.wdata[CTRL_SER] ? OP_SERASE :
                         reg_req_i.wdata[CTRL_MER] ? OP_MERASE :
                                                     OP_OPT;
  wire [1:0] sec_w = sector_of(addr_q);
  wire byte_op_w = (op_w == OP_PROG) || (op_w == OP_SERASE);
  // sector 0 stays writable outside in-application mode
  wire sec_bad_w = byte_op_w &&
                   (sec_w == SEC_NONE ||
                    (iap_w && sec_w == 2'h0));
  // whole-array and option writes would reach sector 0
  wire mode_bad_w = iap_w &&
                    (op_w == OP_MERASE || op_w == OP_OPT);
  wire rdp_bad_w = rdp_q && (op_w != OP_OPT);
  wire start_ok_w = wr_ctrl_w && op_hit_w && armed_w && idle_w &&
                    loaded_q && !sec_bad_w && !mode_bad_w &&
                    !rdp_bad_w;
  wire refuse_w = wr_ctrl_w && op_hit_w && !start_ok_w;
  wire unprot_w = (op_w == OP_OPT) && rdp_q &&
                  !data_q[RDP_BIT];
  wire done_w = flash_done_i && cmd_q.req;

  // link edges from the sampled clock
  wire link_on_w = icc_s && att_s;
  wire rise_w    = link_on_w && sclk_s && !sclk_prev_q;
  wire fall_w    = link_on_w && !sclk_s && sclk_prev_q;
  wire byte_w    = rise_w && cnt_q == LINK_LAST;
  wire rx_done_w = byte_w && !txp_q;
  wire tx_load_w = wr_link_w && !txp_q && cnt_q == 3'h0;
  wire link_refuse_w = wr_link_w && !tx_load_w;

  wire [7:0] stat_w = {1'b0, armed_w, txp_q, rxv_q, att_s, rdp_q, err_q,
                       !idle_w};
  wire [7:0] rmux_w =
    reg_req_i.addr == ADDR_CTRL  ? ctrl_q :
    reg_req_i.addr == ADDR_ADRLO ? addr_q[7:0] :
    reg_req_i.addr == ADDR_ADRHI ? addr_q[15:8] :
    reg_req_i.addr == ADDR_DATA  ? data_q :
    reg_req_i.addr == ADDR_STAT  ? stat_w :
    reg_req_i.addr == ADDR_LINK  ? rx_q : 8'h00;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      sclk_prev_q <= 1'b0;
    end else if (ce_i) begin
      sync1_q <= pins_w;
      sync2_q <= sync1_q;
      sclk_prev_q <= sclk_s;
    end
  end

  // guard: key1 then key2 arms one start; any control write disarms
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      guard_q <= GUARD_IDLE;
    end else if (ce_i) begin
      if (wr_ctrl_w)
        guard_q <= GUARD_IDLE;
      else if (wr_guard_w)
        guard_q <= reg_req_i.wdata == GUARD_KEY1 ? GUARD_HALF :
                   (guard_q == GUARD_HALF &&
                    reg_req_i.wdata == GUARD_KEY2) ? GUARD_ARMED :
                   GUARD_IDLE;
    end
  end

  // address and data are frozen while an operation runs
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      addr_q <= 16'h0000;
      data_q <= 8'h00;
    end else if (ce_i && idle_w) begin
      if (wr_lo_w) addr_q[7:0] <= reg_req_i.wdata;
      if (wr_hi_w) addr_q[15:8] <= reg_req_i.wdata;
      if (wr_data_w) data_q <= reg_req_i.wdata;
    end
  end

  // sticky error: a new refusal wins over the clear
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i)
      err_q <= 1'b0;
    else if (ce_i)
      err_q <= refuse_w || link_refuse_w ||
               (err_q && !(wr_stat_w && reg_req_i.wdata[STAT_ERR]));
  end

  // operation sequencer
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      ctrl_q <= CTRL_RESET;
    end else if (ce_i) begin
      case (state_q)
        ST_IDLE: begin
          if (start_ok_w) begin
            ctrl_q <= 8'(8'h01 << op_w);
            cmd_q.req <= 1'b1;
            cmd_q.op <= unprot_w ? OP_MERASE : op_w;
            cmd_q.addr <= addr_q;
            cmd_q.data <= data_q;
            state_q <= unprot_w ? ST_UNPROT_ERASE : ST_RUN;
          end
        end
        ST_UNPROT_ERASE: begin
          // option cleared only after the array is blank
          if (done_w) begin
            cmd_q.op <= OP_OPT;
            state_q <= ST_UNPROT_CLR;
          end
        end
        ST_RUN, ST_UNPROT_CLR: begin
          if (done_w) begin
            cmd_q.req <= 1'b0;
            ctrl_q <= CTRL_RESET;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // protection bit: loaded once after reset, then tracks option writes
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdp_q <= 1'b0;
      loaded_q <= 1'b0;
    end else if (ce_i) begin
      loaded_q <= 1'b1;
      if (!loaded_q)
        rdp_q <= flash_opt_rdp_i;
      else if (done_w && cmd_q.op == OP_OPT)
        rdp_q <= cmd_q.data[RDP_BIT];
    end
  end

  // serial link: sample on rising clock, drive on falling clock
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 3'h0;
      shift_q <= 8'h00;
      rx_q <= 8'h00;
    end else if (ce_i) begin
      if (!link_on_w) begin
        cnt_q <= 3'h0;
      end else if (rise_w) begin
        cnt_q <= 3'(cnt_q + 3'h1);
        shift_q <= {shift_q[6:0], sdat_s};
        if (rx_done_w) rx_q <= {shift_q[6:0], sdat_s};
      end
    end
  end

  // receive flag: a byte landing on the read cycle stays flagged
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i)
      rxv_q <= 1'b0;
    else if (ce_i)
      rxv_q <= rx_done_w || (rxv_q && !rd_link_w);
  end

  // transmit: one whole byte per load, line released afterwards
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_q <= 8'h00;
      txp_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (ce_i) begin
      if (tx_load_w) begin
        tx_q <= reg_req_i.wdata;
        txp_q <= 1'b1;
      end else if (byte_w) begin
        txp_q <= 1'b0;
      end else if (fall_w && txp_q && cnt_q != 3'h0) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
      oe_q <= link_on_w && txp_q && !byte_w;
    end
  end

  // register read data and status pins
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
      released_q <= 1'b1;
      rblock_q <= 1'b0;
    end else if (ce_i) begin
      rdata_q <= reg_req_i.re ? rmux_w : 8'h00;
      released_q <= !att_s;
      rblock_q <= rdp_q && (!iap_w || att_s);
    end
  end

  assign rdata_o = rdata_q;
  assign flash_cmd_o = cmd_q;
  assign incircuit_serial_data_o = tx_q[7];
  assign incircuit_serial_data_oe_o = oe_q;
  assign app_pins_released_o = released_q;
  assign readout_block_o = rblock_q;

  // checks
  property p_iap_sec0;
    @(posedge core_clk_i) disable iff (reset_i)
    ($rose(cmd_q.req) && $past(iap_w)) |->
      (cmd_q.op inside {OP_PROG, OP_SERASE}) &&
      sector_of(cmd_q.addr) inside {2'h1, 2'h2};
  endproperty
  a_iap_sec0: assert property (p_iap_sec0)
    else $error("sector 0 or whole array touched in app mode");

  property p_rdp_block;
    @(posedge core_clk_i) disable iff (reset_i)
    ($rose(cmd_q.req) && $past(rdp_q)) |->
      cmd_q.op inside {OP_MERASE, OP_OPT};
  endproperty
  a_rdp_block: assert property (p_rdp_block)
    else $error("flash write issued while protected");

  property p_unprot;
    @(posedge core_clk_i) disable iff (reset_i)
    $fell(rdp_q) |->
      $past(state_q == ST_UNPROT_CLR && flash_done_i);
  endproperty
  a_unprot: assert property (p_unprot)
    else $error("protection cleared without prior array erase");

  property p_unprot_order;
    @(posedge core_clk_i) disable iff (reset_i)
    (state_q == ST_UNPROT_ERASE && cmd_q.req) |->
      cmd_q.op == OP_MERASE;
  endproperty
  a_unprot_order: assert property (p_unprot_order)
    else $error("unprotect did not start with a whole erase");

  property p_guard;
    @(posedge core_clk_i) disable iff (reset_i)
    $rose(cmd_q.req) |-> $past(guard_q) == GUARD_ARMED;
  endproperty
  a_guard: assert property (p_guard)
    else $error("operation started without guard armed");

  property p_sector;
    @(posedge core_clk_i) disable iff (reset_i)
    (cmd_q.req && cmd_q.op inside {OP_PROG, OP_SERASE}) |->
      sector_of(cmd_q.addr) != SEC_NONE;
  endproperty
  a_sector: assert property (p_sector)
    else $error("operation outside the array");

  property p_hold;
    @(posedge core_clk_i) disable iff (reset_i)
    (ce_i && cmd_q.req && !flash_done_i) |=>
      cmd_q.req && $stable(cmd_q.addr) && $stable(cmd_q.data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("command changed before completion");

  property p_refuse;
    @(posedge core_clk_i) disable iff (reset_i)
    (ce_i && refuse_w && idle_w) |=> err_q && !cmd_q.req;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("refused request was not dropped");

  property p_pins;
    @(posedge core_clk_i) disable iff (reset_i)
    (ce_i && att_s) |=> !app_pins_released_o;
  endproperty
  a_pins: assert property (p_pins)
    else $error("link pins released while tool attached");

  property p_ctrl_idle;
    @(posedge core_clk_i) disable iff (reset_i)
    (state_q == ST_IDLE) |-> ctrl_q == CTRL_RESET;
  endproperty
  a_ctrl_idle: assert property (p_ctrl_idle)
    else $error("control register not clear while idle");

  property p_oe;
    @(posedge core_clk_i) disable iff (reset_i)
    incircuit_serial_data_oe_o |-> txp_q && $past(link_on_w);
  endproperty
  a_oe: assert property (p_oe)
    else $error("data line driven with no byte pending");

  c_prog: cover property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(cmd_q.req) && cmd_q.op == OP_PROG);
  c_unprot: cover property (@(posedge core_clk_i) disable iff (reset_i)
    $fell(rdp_q));
  c_rx: cover property (@(posedge core_clk_i) disable iff (reset_i)
    rx_done_w);
  c_tx: cover property (@(posedge core_clk_i) disable iff (reset_i)
    $fell(txp_q));

endmodule // flash_sector_access_control

// file: testbench/tool_link_model.sv
// behavioural programming tool on the in-circuit link
`timescale 1ns/1ps
module tool_link_model (
  // link pins
  output logic      sclk_o,
  output logic      sdata_o,
  input  wire logic line_i,
  // session pins
  output logic      attached_o,
  output logic      comm_mode_o
);
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b1;
    attached_o = 1'b0;
    comm_mode_o = 1'b0;
  end
  // plug first, then switch mode; pins move away from core edges
  task automatic attach(input logic a, input logic m);
    #7 attached_o = a;
    #50 comm_mode_o = m;
  endtask
  // msb first; clock stands low between frames
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #7;
    for (int i = 7; i >= 0; i--) begin
      sdata_o = tx[i];
      #100 sclk_o = 1'b1;
      // sampled in the high phase: device shift lags the pin by syncs
      #50 rx[i] = line_i;
      #50 sclk_o = 1'b0;
    end
    // released line never keeps a stale level
    sdata_o = ~sdata_o;
  endtask
endmodule // tool_link_model

// file: testbench/flash_sector_access_control_bench.sv
// self-checking bench for the flash sector access controller
`timescale 1ns/1ps
module flash_sector_access_control_bench;
  import flash_access_pkg::*;
  logic       clk;
  logic       rst;
  reg_req_t   req;
  logic [7:0] rdata;
  logic       offb;
  logic       rdp_in;
  logic       ce;
  logic       done = 1'b0;
  logic [1:0] cnt_q = 2'h0;
  flash_cmd_t cmd;
  flash_cmd_t log_q[$];
  logic       sclk, tdat, line, dout, doe, icm, att, rel, blk;
  logic [7:0] rx;
  int         n_fail, comparisons, cycles;

  assign line = doe ? dout : tdat;

  flash_sector_access_control flash_sector_access_control_inst (
    .core_clk_i(clk), .reset_i(rst), .ce_i(ce),
    .reg_req_i(req), .rdata_o(rdata),
    .offboard_tool_i(offb), .incircuit_comm_mode_i(icm),
    .tool_attached_i(att), .incircuit_serial_clock_i(sclk),
    .incircuit_serial_data_i(line), .incircuit_serial_data_o(dout),
    .incircuit_serial_data_oe_o(doe), .app_pins_released_o(rel),
    .readout_block_o(blk), .flash_cmd_o(cmd),
    .flash_done_i(done), .flash_opt_rdp_i(rdp_in));

  tool_link_model tool_link_model_inst (
    .sclk_o(sclk), .sdata_o(tdat), .line_i(line),
    .attached_o(att), .comm_mode_o(icm));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // flash macro: done two cycles after each request is seen
  always @(posedge clk) begin
    done <= cmd.req && !done && cnt_q == 2'h2;
    cnt_q <= (cmd.req && !done) ? cnt_q + 2'h1 : 2'h0;
    if (done) log_q.push_back(cmd);
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string s, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk);
  endtask

  task automatic idle();
    req <= '0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  // reset only while no link session is open
  task automatic do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic mode(input logic tool, a, m);
    offb <= tool;
    tool_link_model_inst.attach(a, m);
    repeat (6) @(posedge clk);
  endtask

  // one start, guarded when key is set; n is how many macro operations must follow
  task automatic run(input logic [15:0] a, input logic [7:0] d, c,
                     input logic key, input int n, input flash_op_t op);
    logic [7:0] v;
    int         k;
    log_q.delete();
    wr(ADDR_ADRLO, a[7:0]);
    wr(ADDR_ADRHI, a[15:8]);
    wr(ADDR_DATA, d);
    if (key) begin
      wr(ADDR_GUARD, GUARD_KEY1);
      wr(ADDR_GUARD, GUARD_KEY2);
    end
    wr(ADDR_CTRL, c);
    rd(ADDR_CTRL, v);
    chk("ctrl", (n > 0) ? c : 8'h00, v);
    k = 0;
    while (cmd.req !== 1'b0 && k < 40) begin
      @(posedge clk);
      k++;
    end
    rd(ADDR_STAT, v);
    chk("err", 8'(n == 0), 8'(v[STAT_ERR]));
    wr(ADDR_STAT, 8'h02);
    idle();
    chk("ops", 8'(n), 8'(log_q.size()));
    if (n > 0) chk("op", 8'(op), 8'(log_q[n-1].op));
    if (n > 0 && op == OP_PROG) begin
      chk("adr lo", a[7:0], log_q[0].addr[7:0]);
      chk("adr hi", a[15:8], log_q[0].addr[15:8]);
      chk("data", d, log_q[0].data);
    end
  endtask

  task automatic t_reset();
    logic [7:0] v;
    rd(ADDR_CTRL, v);
    chk("ctrl rst", CTRL_RESET, v);
    wr(3'h7, 8'hFF);
    rd(3'h7, v);
    chk("unmapped", 8'h00, v);
    // a write while the enable is low must not land
    ce <= 1'b0;
    wr(ADDR_DATA, 8'hA5);
    ce <= 1'b1;
    rd(ADDR_DATA, v);
    chk("frozen", 8'h00, v);
    chk("released", 8'h01, 8'(rel));
    chk("blocked", 8'h00, 8'(blk));
  endtask

  task automatic t_tool();
    mode(1'b1, 1'b0, 1'b0);
    run(16'hF000, 8'h5A, 8'h01, 1'b1, 1, OP_PROG);
    run(16'hF123, 8'h00, 8'h02, 1'b1, 1, OP_SERASE);
    run(16'h0000, 8'h00, 8'h04, 1'b1, 1, OP_MERASE);
    run(16'h7FFF, 8'h00, 8'h01, 1'b1, 0, OP_PROG);
    run(16'h8000, 8'h00, 8'h02, 1'b1, 1, OP_SERASE);
    run(16'hF000, 8'h33, 8'h01, 1'b0, 0, OP_PROG);
  endtask

  task automatic t_iap();
    mode(1'b0, 1'b0, 1'b0);
    run(16'hF000, 8'hC3, 8'h01, 1'b1, 0, OP_PROG);
    run(16'hEFFF, 8'h11, 8'h01, 1'b1, 1, OP_PROG);
    run(16'hE000, 8'h00, 8'h02, 1'b1, 1, OP_SERASE);
    run(16'hFFFF, 8'h00, 8'h02, 1'b1, 0, OP_SERASE);
    run(16'h0000, 8'h00, 8'h04, 1'b1, 0, OP_MERASE);
  endtask

  task automatic t_prot();
    logic [7:0] v;
    rdp_in <= 1'b1;
    do_reset();
    mode(1'b1, 1'b0, 1'b0);
    chk("blocked", 8'h01, 8'(blk));
    run(16'hE000, 8'h77, 8'h01, 1'b1, 0, OP_PROG);
    run(16'h0000, 8'h00, 8'h08, 1'b1, 2, OP_OPT);
    chk("erase first", 8'(OP_MERASE), 8'(log_q[0].op));
    rd(ADDR_STAT, v);
    chk("rdp off", 8'h00, 8'(v[STAT_RDP]));
    chk("unblocked", 8'h00, 8'(blk));
    run(16'h0000, 8'h01, 8'h08, 1'b1, 1, OP_OPT);
    rd(ADDR_STAT, v);
    chk("rdp on", 8'h01, 8'(v[STAT_RDP]));
    rdp_in <= 1'b0;
    do_reset();
  endtask

  task automatic t_link();
    logic [7:0] v;
    mode(1'b0, 1'b1, 1'b0);
    chk("pins held", 8'h00, 8'(rel));
    mode(1'b0, 1'b1, 1'b1);
    run(16'hF000, 8'h96, 8'h01, 1'b1, 1, OP_PROG);
    tool_link_model_inst.xfer(8'hA5, rx);
    @(posedge clk);
    repeat (2) @(posedge clk);
    rd(ADDR_STAT, v);
    chk("rx valid", 8'h01, 8'(v[STAT_RXV]));
    rd(ADDR_LINK, v);
    chk("rx byte", 8'hA5, v);
    wr(ADDR_LINK, 8'h3C);
    idle();
    tool_link_model_inst.xfer(8'h00, rx);
    @(posedge clk);
    chk("tx byte", 8'h3C, rx);
    repeat (4) @(posedge clk);
    chk("oe off", 8'h00, 8'(doe));
    mode(1'b0, 1'b0, 1'b0);
    chk("pins free", 8'h01, 8'(rel));
  endtask

  initial begin
    rst = 1'b1;
    req = '0;
    offb = 1'b0;
    ce = 1'b1;
    rdp_in = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_tool();
    t_iap();
    t_prot();
    t_link();
    give_verdict();
  end
endmodule // flash_sector_access_control_bench
